// [include/phy_mac_pkg.sv]
// constants and helpers shared by the MAC data interface port logic
package phy_mac_pkg;

    localparam int unsigned CLK_HZ     = 25_000_000;
    localparam int unsigned MII10_HZ   = 2_500_000;
    localparam int unsigned SNI_HZ     = 10_000_000;
    localparam int unsigned RMII_REF_HZ = 50_000_000;

    // clock cycles between sample ticks; sni alternates two whole counts
    localparam logic [3:0] DIV_FULL   = 4'h1;
    localparam logic [3:0] DIV_MII10  = 4'(CLK_HZ / MII10_HZ);
    localparam logic [3:0] DIV_SNI_LO = 4'(CLK_HZ / SNI_HZ);
    localparam logic [3:0] DIV_SNI_HI = 4'((CLK_HZ + SNI_HZ - 1) / SNI_HZ);

    localparam logic [1:0] MODE_MII  = 2'h0;
    localparam logic [1:0] MODE_RMII = 2'h1;
    localparam logic [1:0] MODE_SNI  = 2'h2;

    localparam logic [3:0] NIB_ZERO  = 4'h0;
    localparam logic [1:0] CNT_ZERO  = 2'h0;
    localparam logic [1:0] CORRUPT_DIBIT = 2'h3;

    // last tick index of one nibble: 1, 2 or 4 ticks per nibble
    function automatic logic [1:0] nib_last(input logic [1:0] mode);
        case (mode)
            MODE_RMII: nib_last = 2'h1;
            MODE_SNI:  nib_last = 2'h3;
            default:   nib_last = 2'h0;
        endcase
    endfunction : nib_last

    // tick period for the given mode, rate and alternation phase
    function automatic logic [3:0] tick_div(input logic [1:0] mode,
                                            input logic       speed_100,
                                            input logic       phase);
        case (mode)
            MODE_MII:  tick_div = speed_100 ? DIV_FULL : DIV_MII10;
            MODE_SNI:  tick_div = phase ? DIV_SNI_LO : DIV_SNI_HI;
            default:   tick_div = DIV_FULL;
        endcase
    endfunction : tick_div

endpackage : phy_mac_pkg

// [core/tick_gen.sv]
// sample tick and clock level generator for one direction of a port
`timescale 1ns/100ps
`default_nettype none
module tick_gen (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [3:0] per_a,
    input  wire logic [3:0] per_b,
    output logic            tick,
    output logic            lvl
);
    typedef struct packed {
        logic [3:0] cnt;
        logic       phase;
        logic       tick;
        logic       lvl;
    } tick_state_t;

    tick_state_t st_r;
    tick_state_t st_nxt;
    logic [3:0]  per_cur;

    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        per_cur     = st_r.phase ? per_b : per_a;
        if (st_r.cnt == 4'h0)
        begin
            st_nxt.tick  = 1'b1;
            st_nxt.cnt   = per_cur - 4'h1;
            st_nxt.phase = ~st_r.phase;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt - 4'h1;
        end
        // high for the first half of each period, ticks on the rising side
        st_nxt.lvl = (st_nxt.cnt >= {1'b0, per_cur[3:1]});
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign tick = st_r.tick;
    assign lvl  = st_r.lvl;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_tick_not_back: assert property (
        tick && per_a > 4'h1 && per_b > 4'h1 |=> !tick)
        else $error("tick repeated in a slow mode");

    sequence s_ten_gap;
        (!tick)[*8] ##1 !tick ##1 tick;
    endsequence

    a_tick_period_ten: assert property (
        tick && per_a == 4'ha && per_b == 4'ha && $stable(per_a) |=> s_ten_gap)
        else $error("slow mii tick period is not ten cycles");

endmodule : tick_gen
`default_nettype wire

// [core/tx_packer.sv]
// gathers nibbles, dibits or serial bits from the mac into line nibbles
`timescale 1ns/100ps
`default_nettype none
module tx_packer (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [1:0] mode,
    input  wire logic       tick,
    input  wire logic       en,
    input  wire logic [3:0] data,
    output logic [3:0]      nib,
    output logic            nib_vld,
    output logic            active
);
    typedef struct packed {
        logic [3:0] acc;
        logic [1:0] cnt;
        logic [3:0] nib;
        logic       vld;
        logic       active;
    } pack_state_t;

    pack_state_t st_r;
    pack_state_t st_nxt;
    logic [3:0]  shifted;

    always_comb
    begin
        st_nxt     = st_r;
        st_nxt.vld = 1'b0;
        case (mode)
            phy_mac_pkg::MODE_RMII: shifted = {data[1:0], st_r.acc[3:2]};
            phy_mac_pkg::MODE_SNI:  shifted = {data[0], st_r.acc[3:1]};
            default:                shifted = data;
        endcase
        if (tick)
        begin
            st_nxt.active = en;
            if (en)
            begin
                st_nxt.acc = shifted;
                if (st_r.cnt == phy_mac_pkg::nib_last(mode))
                begin
                    st_nxt.cnt = phy_mac_pkg::CNT_ZERO;
                    st_nxt.nib = shifted;
                    st_nxt.vld = 1'b1;
                end
                else
                begin
                    st_nxt.cnt = st_r.cnt + 2'h1;
                end
            end
            else
            begin
                // a partial nibble at frame end is dropped, no padding
                st_nxt.cnt = phy_mac_pkg::CNT_ZERO;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign nib     = st_r.nib;
    assign nib_vld = st_r.vld;
    assign active  = st_r.active;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_mii_nibble_pass: assert property (
        mode == phy_mac_pkg::MODE_MII && tick && en |=> nib_vld && nib == $past(data))
        else $error("mii nibble not passed on its tick");

    sequence s_first_dibit;
        tick && en && st_r.cnt == 2'h0 && mode == phy_mac_pkg::MODE_RMII;
    endsequence

    // rmii ticks every cycle, so the second dibit is taken on the very next edge
    a_rmii_dibit_pair: assert property (
        s_first_dibit ##1 (tick && en && $stable(mode))
        |=> nib_vld)
        else $error("two rmii dibits did not form a nibble");

endmodule : tx_packer
`default_nettype wire

// [core/mac_data_port.sv]
// one port of the phy-side mac data interface: mii, rmii or sni
// Notes on behaviour
// - mii transmit clock 2.5 MHz at 10, held high at 100
// - rmii leaves clock outputs unused, reference timed
// - sni 10 MHz transmit clock; mac launches on it
// - mii transmit nibble sampled on transmit clock at 10, every clock at 100
// - rmii transmit dibits sampled on reference clock
// - sni serial transmit bit sampled on clock
// - mii receive clock 2.5 MHz at 10, held high at 100
// - sni receive clock 10 MHz
// - mii receive valid marks valid nibbles
// - rmii still drives separate receive valid
// - sni leaves receive valid and error unused
// - mii 100 invalid symbol raises receive error
// - rmii 100 invalid symbol under crs_dv errors
// - rmii false carrier raises receive error
// - rmii corrupts receive data on error
// - management data line shared, phase-driven
// - rmii receive dibits on reference clock
// - sni receive bit 0, upper bits unused
// - full duplex holds collision at zero
`timescale 1ns/100ps
`default_nettype none
module mac_data_port (
    input  wire logic       CLK,
    input  wire logic       RST_B,
    input  wire logic [1:0] MODE,
    input  wire logic       SPEED_100,
    input  wire logic       FULL_DUPLEX,
    input  wire logic       TX_EN,
    input  wire logic [3:0] TXD,
    output logic            TX_CLK,
    output logic            RX_CLK,
    output logic [3:0]      RXD,
    output logic            RX_DV,
    output logic            RX_ER,
    output logic            CRS_DV,
    output logic            COL,
    output logic [3:0]      LINE_TX_DATA,
    output logic            LINE_TX_STB,
    output logic            LINE_TX_ACTIVE,
    input  wire logic [3:0] LINE_RX_DATA,
    input  wire logic       LINE_RX_VALID,
    input  wire logic       LINE_SYM_ERR,
    input  wire logic       LINE_FALSE_CARRIER,
    input  wire logic       LINE_CARRIER,
    input  wire logic       LINE_COLLISION,
    output logic            LINE_RX_TAKE,
    input  wire logic       MDC,
    input  wire logic       MDIO_I,
    output logic            MDIO_O,
    output logic            MDIO_OE,
    input  wire logic       MGMT_MDIO_O,
    input  wire logic       MGMT_MDIO_OE,
    output logic            MGMT_MDC,
    output logic            MGMT_MDIO_I
);
    // one instance per port; nothing here is shared between ports
    typedef struct packed {
        logic [3:0] sh;
        logic [1:0] cnt;
        logic       v_l;
        logic       e_l;
        logic [3:0] rxd;
        logic       rx_dv;
        logic       rx_er;
        logic       crs_dv;
        logic       col;
        logic       take;
        logic       tx_clk;
        logic       rx_clk;
        logic [1:0] mdc_s;
        logic [1:0] mdio_s;
        logic       mdio_o;
        logic       mdio_oe;
    } port_state_t;

    port_state_t st_r;
    port_state_t st_nxt;

    logic       tx_tick;
    logic       tx_lvl;
    logic       rx_tick;
    logic       rx_lvl;
    logic [3:0] per_a;
    logic [3:0] per_b;
    logic       is_mii;
    logic       is_rmii;
    logic       is_sni;
    logic [3:0] cur;
    logic       cur_v;
    logic       cur_e;
    logic       err_now;
    logic [1:0] dibit;

    assign is_mii  = (MODE == phy_mac_pkg::MODE_MII);
    assign is_rmii = (MODE == phy_mac_pkg::MODE_RMII);
    assign is_sni  = (MODE == phy_mac_pkg::MODE_SNI);
    assign per_a   = phy_mac_pkg::tick_div(MODE, SPEED_100, 1'b0);
    assign per_b   = phy_mac_pkg::tick_div(MODE, SPEED_100, 1'b1);

    // transmit and receive share the divider setting; the receive side
    // stands in for the recovered clock and paces the line logic through LINE_RX_TAKE
    tick_gen u_tx_tick (
        .clk   (CLK),
        .rst_b (RST_B),
        .per_a (per_a),
        .per_b (per_b),
        .tick  (tx_tick),
        .lvl   (tx_lvl)
    );

    tick_gen u_rx_tick (
        .clk   (CLK),
        .rst_b (RST_B),
        .per_a (per_a),
        .per_b (per_b),
        .tick  (rx_tick),
        .lvl   (rx_lvl)
    );

    // the mac keeps TX_EN framing its data; the packer trusts it
    tx_packer u_tx_pack (
        .clk     (CLK),
        .rst_b   (RST_B),
        .mode    (MODE),
        .tick    (tx_tick),
        .en      (TX_EN),
        .data    (TXD),
        .nib     (LINE_TX_DATA),
        .nib_vld (LINE_TX_STB),
        .active  (LINE_TX_ACTIVE)
    );

    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.take = 1'b0;
        cur         = (st_r.cnt == phy_mac_pkg::CNT_ZERO) ? LINE_RX_DATA : st_r.sh;
        cur_v       = (st_r.cnt == phy_mac_pkg::CNT_ZERO) ? LINE_RX_VALID : st_r.v_l;
        cur_e       = (st_r.cnt == phy_mac_pkg::CNT_ZERO) ? LINE_SYM_ERR : st_r.e_l;
        err_now     = 1'b0;
        dibit       = cur[1:0];

        st_nxt.tx_clk = tx_lvl && !is_rmii;
        st_nxt.rx_clk = rx_lvl && !is_rmii;

        if (rx_tick)
        begin
            if (st_r.cnt == phy_mac_pkg::CNT_ZERO)
            begin
                st_nxt.take = 1'b1;
                st_nxt.v_l  = LINE_RX_VALID;
                st_nxt.e_l  = LINE_SYM_ERR;
            end
            st_nxt.cnt = (st_r.cnt == phy_mac_pkg::nib_last(MODE)) ?
                         phy_mac_pkg::CNT_ZERO : st_r.cnt + 2'h1;
            case (MODE)
                phy_mac_pkg::MODE_RMII:
                begin
                    st_nxt.sh     = {2'h0, cur[3:2]};
                    st_nxt.crs_dv = LINE_CARRIER || cur_v;
                    err_now = (SPEED_100 && cur_e && st_nxt.crs_dv)
                              || LINE_FALSE_CARRIER;
                    if (err_now)
                        dibit = cur[1:0] ^ phy_mac_pkg::CORRUPT_DIBIT;
                    st_nxt.rxd   = {2'h0, dibit};
                    st_nxt.rx_dv = cur_v;
                    st_nxt.rx_er = err_now;
                    st_nxt.col   = 1'b0;
                end
                phy_mac_pkg::MODE_SNI:
                begin
                    st_nxt.sh     = {1'b0, cur[3:1]};
                    st_nxt.crs_dv = LINE_CARRIER;
                    st_nxt.rxd    = {3'h0, cur[0]};
                    st_nxt.rx_dv  = 1'b0;
                    st_nxt.rx_er  = 1'b0;
                    st_nxt.col    = LINE_COLLISION && !FULL_DUPLEX;
                end
                default:
                begin
                    st_nxt.sh     = phy_mac_pkg::NIB_ZERO;
                    st_nxt.crs_dv = LINE_CARRIER;
                    st_nxt.rxd    = cur;
                    st_nxt.rx_dv  = cur_v;
                    st_nxt.rx_er  = SPEED_100 && cur_v && cur_e;
                    st_nxt.col    = LINE_COLLISION && !FULL_DUPLEX;
                end
            endcase
        end
        if (FULL_DUPLEX)
            st_nxt.col = 1'b0;

        // mdc may run asynchronously to CLK, so both lines are synchronised
        st_nxt.mdc_s   = {st_r.mdc_s[0], MDC};
        st_nxt.mdio_s  = {st_r.mdio_s[0], MDIO_I};
        st_nxt.mdio_o  = MGMT_MDIO_O;
        st_nxt.mdio_oe = MGMT_MDIO_OE;
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign TX_CLK       = st_r.tx_clk;
    assign RX_CLK       = st_r.rx_clk;
    assign RXD          = st_r.rxd;
    assign RX_DV        = st_r.rx_dv;
    assign RX_ER        = st_r.rx_er;
    assign CRS_DV       = st_r.crs_dv;
    assign COL          = st_r.col;
    assign LINE_RX_TAKE = st_r.take;
    assign MDIO_O       = st_r.mdio_o;
    assign MDIO_OE      = st_r.mdio_oe;
    assign MGMT_MDC     = st_r.mdc_s[1];
    assign MGMT_MDIO_I  = st_r.mdio_s[1];

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    a_rmii_clk_quiet: assert property (
        is_rmii && $past(is_rmii) |-> !TX_CLK && !RX_CLK)
        else $error("clock output toggled in rmii mode");

    a_sni_dv_off: assert property (
        is_sni && $past(is_sni) |-> !RX_DV && !RX_ER)
        else $error("receive valid or error driven in sni mode");

    a_sni_upper_zero: assert property (
        is_sni && $past(is_sni) |-> RXD[3:1] == 3'h0)
        else $error("upper receive bits driven in sni mode");

    a_fdx_col_zero: assert property (
        $past(FULL_DUPLEX) |-> !COL)
        else $error("collision asserted in full duplex");

    a_rmii_false_carrier: assert property (
        is_rmii && rx_tick && LINE_FALSE_CARRIER |=> RX_ER)
        else $error("false carrier did not raise receive error");

    a_mii10_no_err: assert property (
        is_mii && !SPEED_100 && $stable(SPEED_100) && $stable(MODE) |=> !RX_ER)
        else $error("receive error raised at 10 Mb/s mii");

    sequence s_rmii_err_tick;
        is_rmii && rx_tick && st_r.cnt == 2'h0 && LINE_RX_VALID && LINE_SYM_ERR
        && SPEED_100;
    endsequence

    a_rmii_corrupt: assert property (
        s_rmii_err_tick |=> RX_ER && RXD[1:0] == ($past(LINE_RX_DATA[1:0]) ^ 2'h3))
        else $error("rmii data not corrupted on receive error");

    a_mdio_oe_follow: assert property (
        MGMT_MDIO_OE |=> MDIO_OE ##0 MDIO_O == $past(MGMT_MDIO_O))
        else $error("mdio drive does not follow management engine");

endmodule : mac_data_port
`default_nettype wire

// [verif/mac_model.sv]
// mac-side transmit model launching enable and data on the device transmit clock, or on every clock in rmii and 100 Mb/s mii
`timescale 1ns/100ps
`default_nettype none
module mac_model (
    input  wire logic       CLK,
    input  wire logic [1:0] MODE,
    input  wire logic       SPEED_100,
    input  wire logic       TX_CLK,
    output logic            TX_EN,
    output logic [3:0]      TXD
);
    initial
    begin
        TX_EN = 1'b0;
        TXD   = 4'h0;
    end

    // launch just after a transmit clock rise so data is steady at the next sample
    task automatic wait_launch(input logic every);
        logic prev;
        int   k;
        k = 0;
        if (every)
            @(negedge CLK);
        else
        begin
            do
            begin
                prev = TX_CLK;
                @(negedge CLK);
                k++;
            end while (!(TX_CLK === 1'b1 && prev === 1'b0) && k < 20);
        end
    endtask : wait_launch

    task automatic send(input logic [15:0] word);
        int   w;
        logic every;
        w     = (MODE == phy_mac_pkg::MODE_RMII) ? 2 : (MODE == phy_mac_pkg::MODE_SNI) ? 1 : 4;
        every = (MODE == phy_mac_pkg::MODE_RMII) || (MODE == phy_mac_pkg::MODE_MII && SPEED_100);
        wait_launch(every);
        for (int j = 0; j < 16 / w; j++)
        begin
            TX_EN = 1'b1;
            TXD   = 4'((word >> (j * w)) & ((16'h1 << w) - 16'h1));
            wait_launch(every);
        end
        TX_EN = 1'b0;
        // released lines must not keep showing the last unit
        TXD   = ~TXD;
    endtask : send
endmodule : mac_model
`default_nettype wire

// [verif/mac_data_port_tb_top.sv]
// self-checking bench for one mac data interface port
`timescale 1ns/100ps
`default_nettype none
module mac_data_port_tb_top;
    logic       CLK, RST_B, SPEED_100, FULL_DUPLEX, TX_EN, TX_CLK, RX_CLK, RX_DV, RX_ER;
    logic       CRS_DV, COL, LINE_TX_STB, LINE_TX_ACTIVE, LINE_RX_VALID, LINE_SYM_ERR;
    logic       LINE_FALSE_CARRIER, LINE_CARRIER, LINE_COLLISION, LINE_RX_TAKE, MDC;
    logic       MDIO_O, MDIO_OE, MGMT_MDIO_O, MGMT_MDIO_OE, MGMT_MDC, MGMT_MDIO_I;
    logic       sme_o, sme_oe;
    logic [1:0] MODE;
    logic [3:0] TXD, RXD, LINE_TX_DATA, LINE_RX_DATA;
    wire        MDIO_I;
    int         n_mismatch = 0;
    int         cmp_count = 0;

    // pulled-up shared management line
    assign MDIO_I = MDIO_OE ? MDIO_O : sme_oe ? sme_o : 1'b1;

    mac_data_port i_dut (
        .CLK(CLK), .RST_B(RST_B), .MODE(MODE), .SPEED_100(SPEED_100),
        .FULL_DUPLEX(FULL_DUPLEX), .TX_EN(TX_EN), .TXD(TXD), .TX_CLK(TX_CLK),
        .RX_CLK(RX_CLK), .RXD(RXD), .RX_DV(RX_DV), .RX_ER(RX_ER), .CRS_DV(CRS_DV),
        .COL(COL), .LINE_TX_DATA(LINE_TX_DATA), .LINE_TX_STB(LINE_TX_STB),
        .LINE_TX_ACTIVE(LINE_TX_ACTIVE), .LINE_RX_DATA(LINE_RX_DATA),
        .LINE_RX_VALID(LINE_RX_VALID), .LINE_SYM_ERR(LINE_SYM_ERR),
        .LINE_FALSE_CARRIER(LINE_FALSE_CARRIER), .LINE_CARRIER(LINE_CARRIER),
        .LINE_COLLISION(LINE_COLLISION), .LINE_RX_TAKE(LINE_RX_TAKE), .MDC(MDC),
        .MDIO_I(MDIO_I), .MDIO_O(MDIO_O), .MDIO_OE(MDIO_OE), .MGMT_MDIO_O(MGMT_MDIO_O),
        .MGMT_MDIO_OE(MGMT_MDIO_OE), .MGMT_MDC(MGMT_MDC), .MGMT_MDIO_I(MGMT_MDIO_I)
    );

    mac_model i_mac (
        .CLK(CLK), .MODE(MODE), .SPEED_100(SPEED_100), .TX_CLK(TX_CLK),
        .TX_EN(TX_EN), .TXD(TXD)
    );

    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    // mode and rate are static, so each change goes through a reset
    task automatic set_mode(input logic [1:0] m, input logic s);
        @(negedge CLK);
        RST_B     = 1'b0;
        MODE      = m;
        SPEED_100 = s;
        repeat (5) @(negedge CLK);
        RST_B = 1'b1;
        repeat (2) @(negedge CLK);
    endtask : set_mode

    task automatic t_clocks(input logic [1:0] m, input logic s, input int rises, input logic lvl);
        int   ntx;
        int   nrx;
        logic ptx;
        logic prx;
        set_mode(m, s);
        ntx = 0;
        nrx = 0;
        ptx = TX_CLK;
        prx = RX_CLK;
        repeat (20)
        begin
            @(negedge CLK);
            ntx += int'(TX_CLK === 1'b1 && ptx === 1'b0);
            nrx += int'(RX_CLK === 1'b1 && prx === 1'b0);
            ptx = TX_CLK;
            prx = RX_CLK;
        end
        check(4'(ntx), 4'(rises));
        check(4'(nrx), 4'(rises));
        if (rises == 0)
            check({TX_CLK, RX_CLK}, {lvl, lvl});
    endtask : t_clocks

    task automatic t_tx(input logic [1:0] m, input logic s);
        logic [15:0] word;
        int          n;
        word = 16'h5ac3;
        n    = 0;
        set_mode(m, s);
        fork
            i_mac.send(word);
            repeat (90)
            begin
                @(negedge CLK);
                if (LINE_TX_STB === 1'b1)
                begin
                    if (n < 4)
                        check(LINE_TX_DATA, word[n*4 +: 4]);
                    check(LINE_TX_ACTIVE, 1'b1);
                    n++;
                end
            end
        join
        check(4'(n), 4'h4);
    endtask : t_tx

    task automatic t_rx(input logic [1:0] m, input logic s, input logic sym, input logic fc,
                        input logic [3:0] rxd, input logic [3:0] rxd2, input logic dv,
                        input logic er);
        int k;
        LINE_RX_DATA       = 4'h9;
        LINE_RX_VALID      = 1'b1;
        LINE_CARRIER       = 1'b1;
        LINE_SYM_ERR       = sym;
        LINE_FALSE_CARRIER = fc;
        set_mode(m, s);
        k = 0;
        do
        begin
            @(negedge CLK);
            k++;
        end while (LINE_RX_TAKE !== 1'b1 && k < 30);
        check(LINE_RX_TAKE, 1'b1);
        check(RXD, rxd);
        check(RX_DV, dv);
        check(RX_ER, er);
        check(CRS_DV, 1'b1);
        @(negedge CLK);
        check(RXD, rxd2);
        LINE_RX_VALID = 1'b0;
        LINE_CARRIER  = 1'b0;
    endtask : t_rx

    task automatic t_col();
        LINE_COLLISION = 1'b1;
        FULL_DUPLEX    = 1'b0;
        set_mode(phy_mac_pkg::MODE_MII, 1'b1);
        repeat (3) @(negedge CLK);
        check(COL, 1'b1);
        FULL_DUPLEX = 1'b1;
        repeat (3) @(negedge CLK);
        check(COL, 1'b0);
        LINE_COLLISION = 1'b0;
    endtask : t_col

    task automatic t_mgmt();
        @(negedge CLK);
        sme_o = 1'b0;
        MDC   = 1'b1;
        @(negedge CLK);
        check(MGMT_MDC, 1'b0);
        @(negedge CLK);
        check(MGMT_MDC, 1'b1);
        check(MGMT_MDIO_I, 1'b0);
        sme_oe       = 1'b0;
        MGMT_MDIO_O  = 1'b1;
        MGMT_MDIO_OE = 1'b1;
        MDC          = 1'b0;
        @(negedge CLK);
        check(MDIO_OE, 1'b1);
        check(MDIO_O, 1'b1);
        repeat (2) @(negedge CLK);
        check(MGMT_MDIO_I, 1'b1);
    endtask : t_mgmt

    initial
    begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end

    initial
    begin
        #(40 * 10000);
        n_mismatch++;
        stop_test();
    end

    initial
    begin
        {RST_B, SPEED_100, FULL_DUPLEX, LINE_RX_VALID, LINE_SYM_ERR} = 5'h00;
        {LINE_FALSE_CARRIER, LINE_CARRIER, LINE_COLLISION, MDC} = 4'h0;
        {MGMT_MDIO_O, MGMT_MDIO_OE, sme_o, sme_oe} = 4'h3;
        MODE         = phy_mac_pkg::MODE_MII;
        LINE_RX_DATA = 4'h0;
        repeat (5) @(negedge CLK);
        RST_B = 1'b1;
        t_clocks(phy_mac_pkg::MODE_MII, 1'b1, 0, 1'b1);
        t_clocks(phy_mac_pkg::MODE_MII, 1'b0, 2, 1'b0);
        t_clocks(phy_mac_pkg::MODE_SNI, 1'b0, 8, 1'b0);
        t_clocks(phy_mac_pkg::MODE_RMII, 1'b1, 0, 1'b0);
        t_tx(phy_mac_pkg::MODE_MII, 1'b1);
        t_tx(phy_mac_pkg::MODE_MII, 1'b0);
        t_tx(phy_mac_pkg::MODE_RMII, 1'b1);
        t_tx(phy_mac_pkg::MODE_SNI, 1'b0);
        t_rx(phy_mac_pkg::MODE_MII, 1'b1, 1'b0, 1'b0, 4'h9, 4'h9, 1'b1, 1'b0);
        t_rx(phy_mac_pkg::MODE_MII, 1'b1, 1'b1, 1'b0, 4'h9, 4'h9, 1'b1, 1'b1);
        t_rx(phy_mac_pkg::MODE_MII, 1'b0, 1'b1, 1'b0, 4'h9, 4'h9, 1'b1, 1'b0);
        t_rx(phy_mac_pkg::MODE_RMII, 1'b1, 1'b0, 1'b0, 4'h1, 4'h2, 1'b1, 1'b0);
        t_rx(phy_mac_pkg::MODE_RMII, 1'b1, 1'b1, 1'b0, 4'h2, 4'h1, 1'b1, 1'b1);
        t_rx(phy_mac_pkg::MODE_RMII, 1'b0, 1'b1, 1'b0, 4'h1, 4'h2, 1'b1, 1'b0);
        t_rx(phy_mac_pkg::MODE_RMII, 1'b1, 1'b0, 1'b1, 4'h2, 4'h1, 1'b1, 1'b1);
        t_rx(phy_mac_pkg::MODE_SNI, 1'b0, 1'b1, 1'b1, 4'h1, 4'h1, 1'b0, 1'b0);
        t_col();
        t_mgmt();
        stop_test();
    end
endmodule : mac_data_port_tb_top
`default_nettype wire
